// *** rtl/sep_pkg.sv ***
// Purpose: shared constants and types for the serial eeprom command port
// Assumes: opcode byte is 0000_x_ccc, x ignored
// Notes:   status layout, opcode codes and self-timed cycle length
package sep_pkg;

   // opcode fields
   localparam logic [3:0] OP_HIGH_ZERO = 4'h0;
   localparam int         OP_HI_MSB    = 7;
   localparam int         OP_HI_LSB    = 4;
   localparam int         OP_CODE_MSB  = 2;
   localparam logic [2:0] OP_PERMIT    = 3'h6;
   localparam logic [2:0] OP_FORBID    = 3'h4;
   localparam logic [2:0] OP_FETCH     = 3'h5;
   localparam logic [2:0] OP_STORE     = 3'h1;
   localparam logic [2:0] OP_READ      = 3'h3;
   localparam logic [2:0] OP_WRITE     = 3'h2;

   // state_and_protection field positions
   localparam int ST_GPE_BIT   = 7;
   localparam int ST_SPARE_HI  = 6;
   localparam int ST_SPARE_LO  = 4;
   localparam int ST_BP_HI     = 3;
   localparam int ST_BP_LO     = 2;
   localparam int ST_WEL_BIT   = 1;
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_WIDTH     = 8;

   // reset values; nonvolatile bits start at factory default
   localparam logic       GPE_RESET   = 1'b0;
   localparam logic [1:0] BP_RESET    = 2'h0;
   localparam logic       WEL_RESET   = 1'b0;
   localparam logic [2:0] SPARE_BUSY  = 3'h7;
   localparam logic [2:0] SPARE_IDLE  = 3'h0;

   // serial framing
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST  = 3'h7;

   // self-timed write cycle
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_WC_MS       = 5;
   localparam int WC_CYCLES_DEF = (T_WC_MS * 1000000) / CLK_PERIOD_NS;
   localparam int WC_CNT_W      = 20;

   // synchroniser reset levels: cs_n, hold_n, wp_n, frame toggle
   localparam logic [3:0] PIN_SYNC_RESET = 4'he;

   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_PERMIT,
      CMD_FORBID,
      CMD_FETCH,
      CMD_STORE,
      CMD_READ,
      CMD_WRITE
   } sep_cmd_e;

   typedef enum logic [2:0] {
      PH_OPCODE,
      PH_STATE_IN,
      PH_STATE_OUT,
      PH_ABSORB,
      PH_DEAD
   } sep_phase_e;

endpackage

// *** rtl/sep_sync.sv ***
// Purpose: two flip-flop synchroniser for levels entering a clock domain
// Assumes: multi-bit use only for bits that are quasi-static
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module sep_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_r <= RESET_VAL;
         o_sync <= RESET_VAL;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end

endmodule
`default_nettype wire

// *** rtl/sep_cmd_port.sv ***
// Purpose: serial command front end of a small serial eeprom
// Assumes: host keeps si, cs_n and hold_n in step with sck (mode 0 or 3)
// Notes:   link logic runs on sck, status and write timer on i_mclk
//
// Contract
// - deselected: ignore input, output high impedance
// - bytes travel most significant bit first
// - sampling starts first rising edge after select
// - read data launched on first falling edge
// - first byte after select is the opcode
// - bad opcode: ignore input until next select
// - pause never stops a running write cycle
// - pause only while selected, lasts while held
// - pause starts now if clock low, else later
// - paused: output off, input ignored, guard live
// - resume at clock low phase
// - deselect while paused aborts, clears write permit
// - guard pin low with enable blocks state writes
// - guard falling mid store cancels it
// - guard enable clear: guard pin ignored
// - eight bit opcode, command starts at select
// - decode permit and forbid opcodes
// - decode state fetch and array read
// - decode state store and array write
// - status byte field layout
// - spare bits read ones during write cycle
// - two bit array guard level field
// - cycle flag shows internal operation running
// - write permit latch clear after reset
// - store changes only bits seven, three, two
// - only fetch while busy, then clear permit
// - sample on rising, launch on falling edge
`timescale 1ns/100ps
`default_nettype none
module sep_cmd_port #(
   parameter int WC_CYCLES = sep_pkg::WC_CYCLES_DEF
) (
   input  wire logic       i_mclk,
   input  wire logic       i_reset_n,
   input  wire logic       i_sck,
   input  wire logic       i_cs_n,
   input  wire logic       i_si,
   input  wire logic       i_hold_n,
   input  wire logic       i_wp_n,
   output logic            o_so,
   output logic            o_so_oe_n,
   output logic            o_busy,
   output logic            o_guard_pin_enable,
   output logic [1:0]      o_guard_level
);

   localparam int CW = sep_pkg::WC_CNT_W;
   localparam logic [CW-1:0] WC_LOAD = CW'(WC_CYCLES - 1);
   localparam logic [CW-1:0] WC_ZERO = '0;

   function automatic sep_pkg::sep_cmd_e decode_op(input logic [7:0] op);
      sep_pkg::sep_cmd_e cmd;
      cmd = sep_pkg::CMD_NONE;
      if (op[sep_pkg::OP_HI_MSB:sep_pkg::OP_HI_LSB] == sep_pkg::OP_HIGH_ZERO)
      begin
         unique case (op[sep_pkg::OP_CODE_MSB:0])
            sep_pkg::OP_PERMIT: cmd = sep_pkg::CMD_PERMIT;
            sep_pkg::OP_FORBID: cmd = sep_pkg::CMD_FORBID;
            sep_pkg::OP_FETCH:  cmd = sep_pkg::CMD_FETCH;
            sep_pkg::OP_READ:   cmd = sep_pkg::CMD_READ;
            sep_pkg::OP_STORE:  cmd = sep_pkg::CMD_STORE;
            sep_pkg::OP_WRITE:  cmd = sep_pkg::CMD_WRITE;
            default:            cmd = sep_pkg::CMD_NONE;
         endcase
      end
      return cmd;
   endfunction

   // ---------------- sck domain ----------------
   logic                   sck_rst_n;
   sep_pkg::sep_phase_e    phase_r;
   logic [2:0]             bit_cnt_r;
   logic [7:0]             shift_r;
   logic [7:0]             shift_nxt;
   logic [7:0]             stat_byte_r;
   logic [2:0]             out_idx_r;
   logic                   so_r;
   logic                   driving_r;
   logic                   paused_r;
   logic                   paused;
   logic                   frame_tog_r;
   sep_pkg::sep_cmd_e      frame_cmd_r;
   logic [7:0]             store_data_r;
   logic [7:0]             status_s;
   logic [7:0]             status_word;
   logic                   busy_s;
   sep_pkg::sep_cmd_e      op_cmd;
   logic                   op_blocked;
   logic                   op_end;
   logic                   data_end;

   // deselect is the frame's own reset; nothing waits for a later sck edge
   assign sck_rst_n = i_reset_n & i_cs_n == 1'b0;
   assign shift_nxt = {shift_r[6:0], i_si};
   assign op_cmd    = decode_op(shift_nxt);
   assign busy_s    = status_s[sep_pkg::ST_BUSY_BIT];
   // while busy only the state fetch is honoured
   assign op_blocked = busy_s & (op_cmd != sep_pkg::CMD_FETCH);
   assign op_end   = (phase_r == sep_pkg::PH_OPCODE)
                   & (bit_cnt_r == sep_pkg::BIT_LAST);
   assign data_end = (phase_r == sep_pkg::PH_STATE_IN)
                   & (bit_cnt_r == sep_pkg::BIT_LAST);

   sep_sync #(
      .WIDTH     (sep_pkg::ST_WIDTH),
      .RESET_VAL ('0)
   ) u_status_sync (
      .i_clk     (i_sck),
      .i_reset_n (i_reset_n),
      .i_async   (status_word),
      .o_sync    (status_s)
   );

   // level of the pause pin at the end of the last low phase
   always_ff @(posedge i_sck or negedge sck_rst_n) begin
      if (!sck_rst_n) begin
         paused_r <= 1'b0;
      end else begin
         paused_r <= ~i_hold_n;
      end
   end

   // low phase follows the pin at once, high phase keeps the edge value
   assign paused = ~i_cs_n & (i_sck ? paused_r : ~i_hold_n);

   // input side; a rising edge with pause held low is ignored
   always_ff @(posedge i_sck or negedge sck_rst_n) begin
      if (!sck_rst_n) begin
         phase_r   <= sep_pkg::PH_OPCODE;
         bit_cnt_r <= sep_pkg::BIT_FIRST;
         shift_r   <= '0;
      end else if (i_hold_n) begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         unique case (phase_r)
            sep_pkg::PH_OPCODE: begin
               shift_r <= shift_nxt;
               if (op_end) begin
                  if (op_blocked) begin
                     phase_r <= sep_pkg::PH_DEAD;
                  end else begin
                     unique case (op_cmd)
                        sep_pkg::CMD_FETCH:
                           phase_r <= sep_pkg::PH_STATE_OUT;
                        sep_pkg::CMD_STORE:
                           phase_r <= sep_pkg::PH_STATE_IN;
                        sep_pkg::CMD_NONE:
                           phase_r <= sep_pkg::PH_DEAD;
                        default:
                           phase_r <= sep_pkg::PH_ABSORB;
                     endcase
                  end
               end
            end
            sep_pkg::PH_STATE_IN: begin
               shift_r <= shift_nxt;
               if (data_end) begin
                  phase_r <= sep_pkg::PH_ABSORB;
               end
            end
            sep_pkg::PH_STATE_OUT,
            sep_pkg::PH_ABSORB,
            sep_pkg::PH_DEAD: begin
               shift_r <= shift_r;
            end
            default: begin
               phase_r <= sep_pkg::PH_DEAD;
            end
         endcase
      end
   end

   // status snapshot refreshed at the opcode end and after each fetched byte so busy can be polled
   always_ff @(posedge i_sck or negedge sck_rst_n) begin
      if (!sck_rst_n) begin
         stat_byte_r <= '0;
      end else if (i_hold_n) begin
         if (op_end || (phase_r == sep_pkg::PH_STATE_OUT
                        && out_idx_r == sep_pkg::BIT_LAST)) begin
            stat_byte_r <= status_s;
         end
      end
   end

   // frame result; survives deselect so i_mclk can read it after cs rises
   always_ff @(posedge i_sck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         frame_cmd_r  <= sep_pkg::CMD_NONE;
         store_data_r <= '0;
         frame_tog_r  <= 1'b0;
      end else if (i_hold_n && !i_cs_n) begin
         if (op_end && !op_blocked
             && (op_cmd == sep_pkg::CMD_PERMIT
                 || op_cmd == sep_pkg::CMD_FORBID
                 || op_cmd == sep_pkg::CMD_WRITE)) begin
            frame_cmd_r <= op_cmd;
            frame_tog_r <= ~frame_tog_r;
         end else if (data_end) begin
            frame_cmd_r  <= sep_pkg::CMD_STORE;
            store_data_r <= shift_nxt;
            frame_tog_r  <= ~frame_tog_r;
         end
      end
   end

   // output side launches on falling edges, most significant bit first
   always_ff @(negedge i_sck or negedge sck_rst_n) begin
      if (!sck_rst_n) begin
         so_r      <= 1'b0;
         out_idx_r <= sep_pkg::BIT_LAST;
         driving_r <= 1'b0;
      end else if (!paused_r && phase_r == sep_pkg::PH_STATE_OUT) begin
         so_r      <= stat_byte_r[out_idx_r];
         out_idx_r <= out_idx_r - 3'h1;
         driving_r <= 1'b1;
      end
   end

   assign o_so      = so_r;
   // enable is active low; off when deselected, paused or not reading
   assign o_so_oe_n = ~(driving_r & ~paused);

   // ---------------- i_mclk domain ----------------
   logic [3:0]             pins_s;
   logic                   cs_s;
   logic                   hold_s;
   logic                   wp_s;
   logic                   tog_s;
   logic                   cs_prev_r;
   logic                   seen_tog_r;
   logic                   cs_rise;
   logic                   cs_fall;
   logic                   new_cmd;
   logic                   guarded;
   logic                   cancel_r;
   logic                   commit_store;
   logic                   commit_write;
   logic                   wc_done;
   logic                   gpe_r;
   logic [1:0]             bp_r;
   logic                   wel_r;
   logic                   busy_r;
   logic [CW-1:0]          wc_cnt_r;

   // frame toggle changes before cs rises, so it is settled at the rise
   sep_sync #(
      .WIDTH     (4),
      .RESET_VAL (sep_pkg::PIN_SYNC_RESET)
   ) u_pin_sync (
      .i_clk     (i_mclk),
      .i_reset_n (i_reset_n),
      .i_async   ({i_cs_n, i_hold_n, i_wp_n, frame_tog_r}),
      .o_sync    (pins_s)
   );

   assign cs_s    = pins_s[3];
   assign hold_s  = pins_s[2];
   assign wp_s    = pins_s[1];
   assign tog_s   = pins_s[0];
   assign cs_rise = cs_s & ~cs_prev_r;
   assign cs_fall = ~cs_s & cs_prev_r;
   // a cs pulse with no completed command leaves the toggle unchanged
   assign new_cmd = cs_rise & hold_s & (tog_s != seen_tog_r);
   assign guarded = gpe_r & ~wp_s;
   assign commit_store = new_cmd & (frame_cmd_r == sep_pkg::CMD_STORE)
                       & wel_r & ~guarded & ~cancel_r;
   assign commit_write = new_cmd & (frame_cmd_r == sep_pkg::CMD_WRITE)
                       & wel_r;
   assign wc_done = busy_r & (wc_cnt_r == WC_ZERO);

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cs_prev_r  <= 1'b1;
         seen_tog_r <= 1'b0;
      end else begin
         cs_prev_r <= cs_s;
         if (cs_rise) begin
            seen_tog_r <= tog_s;
         end
      end
   end

   // guard falling during the frame cancels a pending store; set wins
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cancel_r <= 1'b0;
      end else begin
         if (cs_fall) begin
            cancel_r <= 1'b0;
         end
         if (!cs_s && guarded) begin
            cancel_r <= 1'b1;
         end
      end
   end

   // write permit latch
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wel_r <= sep_pkg::WEL_RESET;
      end else if (wc_done) begin
         wel_r <= 1'b0;
      end else if (cs_rise && !hold_s) begin
         wel_r <= 1'b0;
      end else if (new_cmd && frame_cmd_r == sep_pkg::CMD_PERMIT) begin
         wel_r <= 1'b1;
      end else if (new_cmd && frame_cmd_r == sep_pkg::CMD_FORBID) begin
         wel_r <= 1'b0;
      end
   end

   // only enable and guard level are writable by a store
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gpe_r <= sep_pkg::GPE_RESET;
         bp_r  <= sep_pkg::BP_RESET;
      end else if (commit_store) begin
         gpe_r <= store_data_r[sep_pkg::ST_GPE_BIT];
         bp_r  <= store_data_r[sep_pkg::ST_BP_HI:sep_pkg::ST_BP_LO];
      end
   end

   // self-timed cycle; pause and guard pin cannot stop it once started
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         busy_r   <= 1'b0;
         wc_cnt_r <= WC_ZERO;
      end else if (commit_store || commit_write) begin
         busy_r   <= 1'b1;
         wc_cnt_r <= WC_LOAD;
      end else if (wc_done) begin
         busy_r <= 1'b0;
      end else if (busy_r) begin
         wc_cnt_r <= wc_cnt_r - {{(CW-1){1'b0}}, 1'b1};
      end
   end

   always_comb begin
      status_word = '0;
      status_word[sep_pkg::ST_GPE_BIT] = gpe_r;
      status_word[sep_pkg::ST_SPARE_HI:sep_pkg::ST_SPARE_LO] =
         busy_r ? sep_pkg::SPARE_BUSY : sep_pkg::SPARE_IDLE;
      status_word[sep_pkg::ST_BP_HI:sep_pkg::ST_BP_LO] = bp_r;
      status_word[sep_pkg::ST_WEL_BIT]  = wel_r;
      status_word[sep_pkg::ST_BUSY_BIT] = busy_r;
   end

   assign o_busy             = busy_r;
   assign o_guard_pin_enable = gpe_r;
   assign o_guard_level      = bp_r;

endmodule
`default_nettype wire

// *** verif/sep_cmd_port_sva.sv ***
// Purpose: port checks for the serial eeprom command port
// Assumes: mode 0 host, WC_CYCLES equal to the design's
// Notes:   opcode bits are counted on unpaused sck rises
`timescale 1ns/100ps
`default_nettype none
module sep_cmd_port_sva #(
   parameter int WC_CYCLES = 100
) (
   input wire logic       i_mclk,
   input wire logic       i_reset_n,
   input wire logic       i_sck,
   input wire logic       i_cs_n,
   input wire logic       i_si,
   input wire logic       i_hold_n,
   input wire logic       i_wp_n,
   input wire logic       o_so,
   input wire logic       o_so_oe_n,
   input wire logic       o_busy,
   input wire logic       o_guard_pin_enable,
   input wire logic [1:0] o_guard_level
);
   logic [19:0] busy_cnt;
   logic [3:0]  rise_cnt;
   logic [7:0]  op_r;
   logic        op_bad;
   logic        op_fetch;

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) busy_cnt <= '0;
      else busy_cnt <= o_busy ? busy_cnt + 20'h1 : '0;
   end
   // cs_n high clears the frame, as it does in the design
   always_ff @(posedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         rise_cnt <= '0;
         op_r     <= '0;
      end else if (i_hold_n && rise_cnt < 4'h8) begin
         rise_cnt <= rise_cnt + 4'h1;
         op_r     <= {op_r[6:0], i_si};
      end
   end
   assign op_bad   = |op_r[7:4] || op_r[2:0] == 3'h0 || op_r[2:0] == 3'h7;
   assign op_fetch = op_r == 8'h05 || op_r == 8'h0d;

   sequence s_opcode_done;
      rise_cnt == 4'h8 && i_hold_n;
   endsequence
   sequence s_guarded;
      (o_guard_pin_enable && !i_wp_n) [*3];
   endsequence

   a_desel_float: assert property (
      @(posedge i_mclk) disable iff (!i_reset_n) i_cs_n |-> o_so_oe_n)
      else $error("so driven while deselected");
   a_pause_float: assert property (
      @(posedge i_mclk) disable iff (!i_reset_n)
      (!i_cs_n && !i_hold_n && !i_sck) |-> o_so_oe_n)
      else $error("so driven while paused");
   a_opcode_quiet: assert property (
      @(posedge i_sck) disable iff (i_cs_n || !i_reset_n)
      rise_cnt < 4'h8 |-> o_so_oe_n) else $error("so driven in opcode");
   a_fetch_drive: assert property (
      @(posedge i_sck) disable iff (i_cs_n || !i_reset_n)
      s_opcode_done and op_fetch |-> !o_so_oe_n) else $error("no fetch data");
   a_bad_quiet: assert property (
      @(posedge i_sck) disable iff (i_cs_n || !i_reset_n)
      s_opcode_done and op_bad |-> o_so_oe_n) else $error("bad op answered");
   a_busy_len: assert property (
      @(posedge i_mclk) disable iff (!i_reset_n)
      $fell(o_busy) |-> busy_cnt == WC_CYCLES) else $error("busy length");
   a_busy_max: assert property (
      @(posedge i_mclk) disable iff (!i_reset_n)
      busy_cnt <= WC_CYCLES) else $error("busy too long");
   a_busy_cause: assert property (
      @(posedge i_mclk) disable iff (!i_reset_n)
      $rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2))
      else $error("busy without closed frame");
   a_guard_change: assert property (
      @(posedge i_mclk) disable iff (!i_reset_n)
      !$stable({o_guard_pin_enable, o_guard_level}) |-> $rose(o_busy))
      else $error("guard bits moved without store");
   a_guard_hold: assert property (
      @(posedge i_mclk) disable iff (!i_reset_n) s_guarded |=>
      $stable({o_guard_pin_enable, o_guard_level}))
      else $error("guarded store went through");
endmodule

bind sep_cmd_port sep_cmd_port_sva #(.WC_CYCLES(WC_CYCLES)) u_sva (
   .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_sck(i_sck),
   .i_cs_n(i_cs_n), .i_si(i_si), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n),
   .o_so(o_so), .o_so_oe_n(o_so_oe_n), .o_busy(o_busy),
   .o_guard_pin_enable(o_guard_pin_enable),
   .o_guard_level(o_guard_level));
`default_nettype wire

// *** verif/sep_spi_host.sv ***
// Purpose: mode 0 spi host for the command port
// Assumes: sck idles low and stands still between frames
// Notes:   sck period 6 ns; so sampled just before each sck rise
`timescale 1ns/100ps
`default_nettype none
module sep_spi_host (
   output logic      o_sck,
   output logic      o_cs_n,
   output logic      o_si,
   output logic      o_hold_n,
   input  wire logic i_so,
   input  wire logic i_so_oe_n
);
   logic [7:0] rx_last;
   logic       oe_seen;
   int         nbyte;
   event       got;

   initial begin
      o_sck    = 1'b0;
      o_cs_n   = 1'b1;
      o_si     = 1'b0;
      o_hold_n = 1'b1;
   end
   task automatic sel();
      o_cs_n  = 1'b0;
      oe_seen = 1'b0;
      nbyte   = 0;
      #3;
   endtask
   task automatic desel();
      #3 o_cs_n = 1'b1;
      o_si = ~o_si; // no stale bit on a released line
      #50;
   endtask
   task automatic xfer(input logic [7:0] tx, input bit pause);
      for (int i = 7; i >= 0; i--) begin
         o_si = tx[i];
         if (pause && i == 3) begin
            o_hold_n = 1'b0;
            repeat (2) begin
               #3 o_sck = 1'b1;
               o_si = ~o_si;
               #3 o_sck = 1'b0;
            end
            o_hold_n = 1'b1;
            o_si = tx[i];
         end
         // sample late in the low phase; an undriven line reads inverted
         #3 rx_last = {rx_last[6:0], i_so ^ i_so_oe_n};
         oe_seen = oe_seen | ~i_so_oe_n;
         o_sck = 1'b1;
         #3 o_sck = 1'b0;
      end
      nbyte++;
      -> got;
   endtask
   task automatic abort(input logic [7:0] tx);
      sel();
      xfer(tx, 1'b0);
      o_hold_n = 1'b0;
      #3 o_cs_n = 1'b1;
      #30 o_hold_n = 1'b1;
      #30;
   endtask
endmodule
`default_nettype wire

// *** verif/tb_sep_cmd_port.sv ***
// Purpose: self-checking bench for the command port
// Assumes: short write cycle via WC_CYCLES
// Notes:   fetched bytes are scored against a queue of notes
`timescale 1ns/100ps
`default_nettype none
module tb_sep_cmd_port;
   localparam int WC = 100;
   logic       i_mclk;
   logic       i_reset_n;
   logic       i_wp_n;
   wire logic  sck, cs_n, si, hold_n, so, so_oe_n, busy, gpe;
   wire logic [1:0] level;
   int         n_errors, comparisons, seed, k;
   logic [7:0] exp_q[$];
   logic [7:0] d;

   sep_cmd_port #(.WC_CYCLES(WC)) uut (.i_mclk(i_mclk),
      .i_reset_n(i_reset_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
      .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe_n(so_oe_n),
      .o_busy(busy), .o_guard_pin_enable(gpe), .o_guard_level(level));
   sep_spi_host u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si),
      .o_hold_n(hold_n), .i_so(so), .i_so_oe_n(so_oe_n));

   always #5 i_mclk = ~i_mclk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // the spare opcode bit is random, decoding must ignore it
   function automatic logic [7:0] op(input logic [2:0] code);
      logic x;
      x = 1'($random(seed));
      return {4'h0, x, code};
   endfunction
   always @(u_host.got) begin
      if (u_host.nbyte > 1 && exp_q.size() > 0) begin
         check(u_host.rx_last, exp_q.pop_front());
      end
   end
   task automatic send(input logic [2:0] c, input int n, input logic [7:0] v);
      @(posedge i_mclk) #1;
      u_host.sel();
      u_host.xfer(op(c), 1'b0);
      repeat (n) u_host.xfer(v, 1'b0);
      u_host.desel();
   endtask
   // two status bytes, the first one paused mid-byte
   task automatic fetch(input logic [7:0] exp);
      exp_q.push_back(exp);
      exp_q.push_back(exp);
      @(posedge i_mclk) #1;
      u_host.sel();
      u_host.xfer(op(3'h5), 1'b0);
      u_host.xfer(8'($random(seed)), 1'b1);
      u_host.xfer(8'($random(seed)), 1'b0);
      u_host.desel();
   endtask
   task automatic wp(input logic v);
      @(posedge i_mclk) #1 i_wp_n = v;
   endtask
   task automatic wait_idle();
      k = 0;
      while (busy !== 1'b0 && k < 400) begin
         @(posedge i_mclk);
         k++;
      end
      if (k == 400) begin
         n_errors++;
         summarize();
      end
   endtask

   initial begin
      seed = 8;
      i_mclk = 1'b0;
      i_reset_n = 1'b0;
      i_wp_n = 1'b1;
      repeat (6) @(posedge i_mclk);
      #1 i_reset_n = 1'b1;
      repeat (3) @(posedge i_mclk);
      #1 check({busy, gpe, level, 3'h0, so_oe_n}, 8'h01);
      fetch(8'h00);
      send(3'h6, 0, 0);
      fetch(8'h02);
      send(3'h4, 0, 0);
      fetch(8'h00);
      send(3'h1, 1, 8'h0c);
      fetch(8'h00);
      wp(1'b0);
      for (int b = 0; b < 4; b++) begin
         d = 8'($random(seed));
         d[7] = 1'b0;
         d[3:2] = b[1:0];
         send(3'h6, 0, 0);
         send(3'h1, 1, d);
         fetch({4'h7, b[1:0], 2'h3});
         send(3'h4, 0, 0);
         fetch({4'h7, b[1:0], 2'h3});
         wait_idle();
         fetch({4'h0, b[1:0], 2'h0});
      end
      wp(1'b1);
      send(3'h6, 0, 0);
      send(3'h1, 1, 8'h8c);
      fetch(8'hff);
      wait_idle();
      check({gpe, 5'h0, level}, 8'h83);
      wp(1'b0);
      send(3'h6, 0, 0);
      send(3'h1, 1, 8'h00);
      fetch(8'h8e);
      wp(1'b1);
      fork
         send(3'h1, 1, 8'h00);
         begin
            repeat (4) @(posedge i_mclk);
            #1 i_wp_n = 1'b0;
            repeat (4) @(posedge i_mclk);
            #1 i_wp_n = 1'b1;
         end
      join
      fetch(8'h8e);
      send(3'h1, 1, 8'h00);
      fetch(8'h73);
      wait_idle();
      send(3'h6, 0, 0);
      send(3'h2, 3, 8'($random(seed)));
      fetch(8'h73);
      wait_idle();
      send(3'h3, 3, 8'h00);
      check({7'h0, u_host.oe_seen}, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge i_mclk) #1;
         u_host.sel();
         u_host.xfer(i[0] ? 8'h0f : {i[1], 3'h5, 4'h5}, 1'b0);
         u_host.xfer(op(3'h5), 1'b0);
         check({7'h0, u_host.oe_seen}, 8'h00);
         u_host.desel();
      end
      send(3'h6, 0, 0);
      @(posedge i_mclk) #1;
      u_host.abort(op(3'h6));
      fetch(8'h00);
      check({7'h0, exp_q.size() == 0}, 8'h01);
      summarize();
   end
   initial begin
      #400000;
      n_errors++;
      summarize();
   end
endmodule
`default_nettype wire
